//--- include/cbs_pkg.sv
package cbs_pkg;

  // ----------------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CBS_CNT_W = 24;
  localparam int unsigned CBS_IVL_W = 16;
  localparam int unsigned CBS_BIT_W = 5;
  localparam logic [4:0] CBS_CLKS_PER_IVL = 5'h12;
  localparam logic [4:0] CBS_CLK_LAST = 5'h11;
  localparam logic [15:0] CBS_AZ_CLKS = 16'h0100;
  localparam logic [2:0] CBS_FIRST_CROSS_MAX = 3'h4;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CBS_IDLE = 4'h1,
    CBS_ZERO = 4'h2,
    CBS_INTEG = 4'h4,
    CBS_DONE = 4'h8
  } cbs_state_type;

  typedef struct packed {
    logic auto_zero;
    logic input_on;
    logic ref_out;
  } cbs_front_type;

endpackage

//--- hdl/cbs_sequencer.sv
`timescale 1ns/100ps
module cbs_sequencer
  import cbs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [CBS_IVL_W-1:0] num_intervals_i,
  input wire logic comparator_output_level_i,
  input wire logic bit_rd_i,
  output logic [2:0] front_ctl_o,
  output logic busy_o,
  output logic done_o,
  output logic late_cross_o,
  output logic bit_data_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cbs_state_type state_reg, state_next;
  cbs_front_type front_reg, front_next;
  logic [4:0] clk_reg, clk_next;
  logic [CBS_IVL_W-1:0] ivl_reg, ivl_next;
  logic [15:0] az_reg, az_next;
  logic [CBS_CNT_W-1:0] cnt_reg, cnt_next;
  logic cmp_last_reg, cmp_last_next;
  logic pend_reg, pend_next;
  logic crossed_reg, crossed_next;
  logic [2:0] first_reg, first_next;
  logic late_reg, late_next;
  logic [CBS_BIT_W-1:0] bptr_reg, bptr_next;
  logic bit_reg, bit_next;
  logic busy_reg, busy_next;
  logic ivl_end;

  assign ivl_end = (clk_reg == CBS_CLK_LAST);

  always_comb begin
    state_next = state_reg;
    front_next = front_reg;
    clk_next = clk_reg;
    ivl_next = ivl_reg;
    az_next = az_reg;
    cnt_next = cnt_reg;
    cmp_last_next = cmp_last_reg;
    pend_next = pend_reg;
    crossed_next = crossed_reg;
    first_next = first_reg;
    late_next = late_reg;
    bptr_next = bptr_reg;
    bit_next = bit_reg;
    case (state_reg)
      CBS_IDLE, CBS_DONE: begin
        if (start_i) begin
          state_next = CBS_ZERO;
          front_next = '{auto_zero: 1'b1, input_on: 1'b0, ref_out: 1'b0};
          az_next = '0;
        end
      end
      CBS_ZERO: begin
        // A fresh conversion always accumulates from zero.
        cnt_next = '0;
        ivl_next = '0;
        clk_next = '0;
        pend_next = 1'b0;
        crossed_next = 1'b0;
        first_next = '0;
        late_next = 1'b0;
        bptr_next = '0;
        cmp_last_next = comparator_output_level_i;
        az_next = az_reg + 16'h0001;
        if (az_reg == CBS_AZ_CLKS - 16'h0001) begin
          state_next = CBS_INTEG;
          front_next = '{auto_zero: 1'b0, input_on: 1'b1, ref_out: 1'b1};
        end
      end
      CBS_INTEG: begin
        // Isolated comparator level is taken as synchronous here.
        if (comparator_output_level_i) begin
          cnt_next = cnt_reg + 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
        cmp_last_next = comparator_output_level_i;
        if (comparator_output_level_i != cmp_last_reg) begin
          pend_next = 1'b1;
          crossed_next = 1'b1;
        end
        clk_next = ivl_end ? 5'h00 : clk_reg + 5'h01;
        if (ivl_end) begin
          ivl_next = ivl_reg + 1'b1;
          // Reversal waits as long as needed; nothing forces it.
          if (pend_reg) begin
            front_next.ref_out = ~front_reg.ref_out;
            // A crossing seen on the boundary clock stays pending for the next interval.
            pend_next = (comparator_output_level_i != cmp_last_reg);
          end
          if (!crossed_reg) begin
            if (first_reg == CBS_FIRST_CROSS_MAX - 3'h1) begin
              late_next = 1'b1;
            end else begin
              first_next = first_reg + 3'h1;
            end
          end
          if (ivl_reg + 1'b1 == num_intervals_i) begin
            state_next = CBS_DONE;
            front_next = '{auto_zero: 1'b0, input_on: 1'b0, ref_out: 1'b0};
          end
        end
      end
      default: begin
        state_next = CBS_IDLE;
      end
    endcase
    // Serial readout shifts one bit out per access, LSB first.
    if (bit_rd_i && state_reg == CBS_DONE) begin
      bit_next = cnt_reg[bptr_reg];
      bptr_next = (bptr_reg == CBS_BIT_W'(CBS_CNT_W - 1)) ? '0 : bptr_reg + 1'b1;
    end
    busy_next = (state_next == CBS_ZERO) || (state_next == CBS_INTEG);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= CBS_IDLE;
      front_reg <= '0;
      clk_reg <= '0;
      ivl_reg <= '0;
      az_reg <= '0;
      cnt_reg <= '0;
      cmp_last_reg <= 1'b0;
      pend_reg <= 1'b0;
      crossed_reg <= 1'b0;
      first_reg <= '0;
      late_reg <= 1'b0;
      bptr_reg <= '0;
      bit_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      front_reg <= front_next;
      clk_reg <= clk_next;
      ivl_reg <= ivl_next;
      az_reg <= az_next;
      cnt_reg <= cnt_next;
      cmp_last_reg <= cmp_last_next;
      pend_reg <= pend_next;
      crossed_reg <= crossed_next;
      first_reg <= first_next;
      late_reg <= late_next;
      bptr_reg <= bptr_next;
      bit_reg <= bit_next;
      busy_reg <= busy_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    front_ctl_o = front_reg;
    busy_o = busy_reg;
    done_o = state_reg[3];
    late_cross_o = late_reg;
    bit_data_o = bit_reg;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_zero_first: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == CBS_INTEG) |-> $past(state_reg) != CBS_IDLE)
    else $error("Integration began without auto-zero.");
  a_input_on: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(state_reg == CBS_INTEG) |-> front_reg.input_on && front_reg.ref_out)
    else $error("Input and outward reference not switched on.");
  a_ivl_len: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == CBS_INTEG) && $changed(front_reg.ref_out) |-> clk_reg == 5'h00)
    else $error("Reference reversed off an interval boundary.");
  a_count_up: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == CBS_INTEG) && comparator_output_level_i |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("Counter did not count up.");
  a_count_dn: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == CBS_INTEG) && !comparator_output_level_i
      |=> cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("Counter did not count down.");
  a_reverse: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == CBS_INTEG) && state_next == CBS_INTEG && ivl_end && pend_reg
      |=> front_reg.ref_out != $past(front_reg.ref_out))
    else $error("Pending crossing did not reverse reference.");
  a_no_force: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == CBS_INTEG) && !pend_reg && state_next == CBS_INTEG
      |=> $stable(front_reg.ref_out))
    else $error("Reference reversed without crossing.");
  a_stop: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == CBS_INTEG) && ivl_end && (ivl_reg + 1'b1 == num_intervals_i)
      |=> done_o ##1 $stable(cnt_reg))
    else $error("Conversion did not stop at programmed count.");
  a_clear: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(state_reg == CBS_INTEG) |-> cnt_reg == '0 && ivl_reg == '0)
    else $error("Counters not cleared by auto-zero.");
  a_late_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (state_reg == CBS_INTEG) && ivl_end && !crossed_reg
      && (first_reg == CBS_FIRST_CROSS_MAX - 3'h1) |=> late_cross_o)
    else $error("Missing first crossing was not flagged.");
  a_serial_bit: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    bit_rd_i && (state_reg == CBS_DONE) |=> bit_data_o == $past(cnt_reg[bptr_reg]))
    else $error("Serial bit does not match the counter.");

endmodule

//--- testbench/cbs_front_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Front end seen through the isolated links
// ----------------------------------------------------------------------
module cbs_front_model
  import cbs_pkg::*;
(
  input wire logic mclk_i,
  input wire cbs_front_type front_i,
  input wire logic base_i,
  input wire logic [15:0] flip_at_i,
  output logic comparator_output_level_o
);
  int ramp_cnt = 0;
  always @(posedge mclk_i) begin
    if (front_i.input_on && !front_i.auto_zero) begin
      ramp_cnt <= ramp_cnt + 1;
    end else begin
      ramp_cnt <= 0; // The ramp restarts from the stored zero reference.
    end
  end
  // Only plain levels cross the barrier, so the level is held for the whole cycle.
  assign comparator_output_level_o = base_i ^ (flip_at_i != 0 && ramp_cnt >= flip_at_i);
endmodule

//--- testbench/tb_charge_balance_conversion_sequencer.sv
`timescale 1ns/100ps
module tb_charge_balance_conversion_sequencer
  import cbs_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic bit_rd = 1'b0;
  logic lvl = 1'b0;
  logic cmp, busy, done, late, bitd, r17, r27;
  logic [15:0] nivl = 16'h0001;
  logic [15:0] flip = 16'h0000;
  logic [2:0] front;
  logic [2:0] ph;
  logic [23:0] res;
  int n_errors = 0;
  int tests_run = 0;
  int cyc, az, rev;
  cbs_front_type fr;
  assign fr = cbs_front_type'(front);
  always #4 mclk = ~mclk;
  cbs_sequencer uut (.mclk_i(mclk), .rst_b_i(rst_b), .start_i(start), .num_intervals_i(nivl),
    .comparator_output_level_i(cmp), .bit_rd_i(bit_rd), .front_ctl_o(front), .busy_o(busy),
    .done_o(done), .late_cross_o(late), .bit_data_o(bitd));
  cbs_front_model fe (.mclk_i(mclk), .front_i(fr), .base_i(lvl), .flip_at_i(flip),
    .comparator_output_level_o(cmp));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A second start is pulsed mid-run when again is nonzero; it must not disturb timing.
  task automatic convert(input logic [15:0] n, input int again, input logic l,
    input logic [15:0] f);
    @(posedge mclk);
    nivl <= n;
    lvl <= l;
    flip <= f;
    start <= 1'b1;
    cyc = 0;
    az = 0;
    rev = 0;
    do begin
      @(posedge mclk);
      start <= (again != 0 && cyc == again);
      @(negedge mclk);
      cyc++;
      az += (fr.auto_zero === 1'b1);
      rev += (cyc > 257 && busy === 1'b1 && fr.ref_out !== 1'b1);
      if (cyc == 257) ph = {fr.input_on, fr.ref_out, busy};
      if (cyc == 274) r17 = fr.ref_out;
      if (cyc == 284) r27 = fr.ref_out;
    end while (done !== 1'b1 && cyc < 9000);
  endtask
  task automatic read_res(output logic [23:0] v, output logic b24);
    for (int i = 0; i < 25; i++) begin
      @(posedge mclk);
      bit_rd <= 1'b1;
      @(posedge mclk);
      bit_rd <= 1'b0;
      @(negedge mclk);
      if (i < 24) v[i] = bitd;
      else b24 = bitd;
    end
  endtask
  task automatic stuck(input logic l, input logic [23:0] exp);
    logic b24;
    convert(16'h0005, 100, l, 16'h0000);
    chk(24'(cyc), 24'h00015b);
    chk(24'(az), 24'h000100);
    chk({21'h0, ph}, 24'h000007);
    chk(24'(rev), 24'h000000);
    chk({23'h0, late}, 24'h000001);
    read_res(res, b24);
    chk(res, exp);
    chk({23'h0, b24}, {23'h0, exp[0]});
    $display("stuck level %0d test done", l);
  endtask
  task automatic t_reset();
    @(posedge mclk);
    rst_b <= 1'b0;
    @(negedge mclk);
    chk({17'h0, front, busy, done, late, bitd}, 24'h000000);
    @(posedge mclk);
    rst_b <= 1'b1;
    $display("reset test done");
  endtask
  task automatic t_cross();
    logic b24;
    convert(16'h0003, 0, 1'b1, 16'h0005);
    chk(24'(cyc), 24'h000137);
    chk({23'h0, r17}, 24'h000001);
    chk({23'h0, r27}, 24'h000000);
    chk({23'h0, late}, 24'h000000);
    read_res(res, b24);
    chk(res, 24'hffffd4);
    $display("crossing test done");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    stuck(1'b1, 24'h00005a);
    stuck(1'b0, 24'hffffa6);
    t_reset();
    t_cross();
    tally_and_finish();
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule
